/* drsh_consts.svh */
// constants of the host port
`ifndef DRSH_CONSTS_SVH
`define DRSH_CONSTS_SVH

// control word on bus bits 14..4
`define DRSH_CW_LSB 4
`define DRSH_CW_MSB 14
// self test off, fast clocks
`define DRSH_CW_RESET 11'h002

// stored control word fields
`define DRSH_CW_PAR_EN 0
`define DRSH_CW_SELF_TEST_N 1
`define DRSH_CW_RX1_DEC 2
`define DRSH_CW_RX1_B9 3
`define DRSH_CW_RX1_B10 4
`define DRSH_CW_RX2_DEC 5
`define DRSH_CW_RX2_B9 6
`define DRSH_CW_RX2_B10 7
`define DRSH_CW_TX_PAR_INV 8
`define DRSH_CW_TX_DIV 9
`define DRSH_CW_RX_DIV 10

// divisors and half periods
`define DRSH_DIV_FAST 7'd10
`define DRSH_DIV_SLOW 7'd80
`define DRSH_HALF_FAST 7'd5
`define DRSH_HALF_SLOW 7'd40
`define DRSH_GAP_HALVES 4'd8
`define DRSH_LAST_BIT 5'd31
`define DRSH_FIFO_DEPTH 8
`define DRSH_WORD_W 32

`endif

/* drsh_pkg.sv */
// shared types of the host port
package drsh_pkg;

    typedef logic [31:0] drsh_word_t;
    typedef logic [10:0] drsh_cw_t;

    typedef enum logic [1:0]
    {
        DRSH_TX_IDLE = 2'b00,
        DRSH_TX_DATA = 2'b01,
        DRSH_TX_NULL = 2'b11,
        DRSH_TX_GAP = 2'b10
    } drsh_tx_state_t;

    // bit 1: one level, bit 0: zero level
    typedef enum logic [1:0]
    {
        DRSH_LN_NULL = 2'b00,
        DRSH_LN_ZERO = 2'b01,
        DRSH_LN_ONE = 2'b10,
        DRSH_LN_BAD = 2'b11
    } drsh_line_t;

endpackage : drsh_pkg

/* drsh_fifo_if.sv */
// valid/ready carrier to the transmit fifo
`timescale 1ns/1ps
`default_nettype none
interface drsh_fifo_if #(parameter int W = 32);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
endinterface : drsh_fifo_if
`default_nettype wire

/* drsh_fifo.sv */
// transmit fifo with registered head
`timescale 1ns/1ps
`default_nettype none
module drsh_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clr_in,
    drsh_fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
    logic [WIDTH-1:0] head;
    logic [PW-1:0] next_rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW:0] next_count;
    logic [WIDTH-1:0] next_head;
    logic push;
    logic pop;

    assign f.in_ready = (count != DEPTH[PW:0]);
    assign f.out_valid = (count != '0);
    assign f.out_data = head;

    // ------------------------------------------------------------
    // pointers and head register
    // ------------------------------------------------------------
    always_comb
    begin
        push = f.in_valid && f.in_ready;
        pop = f.out_ready && f.out_valid;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        // bypass keeps head right on write to empty slot
        if (push && (wr_ptr == next_rd_ptr))
        begin
            next_head = f.in_data;
        end
        else
        begin
            next_head = mem[next_rd_ptr];
        end
        if (clr_in)
        begin
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
            head <= '0;
        end
        else
        begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
            head <= next_head;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push && !clr_in)
        begin
            mem[wr_ptr] <= f.in_data;
        end
    end

endmodule : drsh_fifo
`default_nettype wire

/* drsh_rx.sv */
// one receiver: decode, assemble, match, flag
`timescale 1ns/1ps
`default_nettype none
`include "drsh_consts.svh"
module drsh_rx
    import drsh_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clr_in,
    input wire logic [1:0] line_in,
    input wire logic decode_en_in,
    input wire logic [1:0] match_in,
    input wire logic [6:0] bit_time_in,
    input wire logic read_in,
    input wire logic read_sel_in,
    output logic [31:0] word_out,
    output logic ready_n_out
);
    drsh_line_t prev_line;
    drsh_line_t next_prev_line;
    drsh_line_t line;
    drsh_word_t shift;
    drsh_word_t next_shift;
    drsh_word_t next_word;
    logic [4:0] nbits;
    logic [4:0] next_nbits;
    logic [6:0] ncnt;
    logic [6:0] next_ncnt;
    logic [1:0] got;
    logic [1:0] next_got;
    logic next_ready_n;
    logic eos;

    always_comb
    begin
        line = drsh_line_t'(line_in);
        next_prev_line = line;
        next_shift = shift;
        next_nbits = nbits;
        next_ncnt = ncnt;
        next_word = word_out;
        next_ready_n = ready_n_out;
        next_got = got;
        eos = 1'b0;
        if (line == DRSH_LN_BAD)
        begin
            next_nbits = '0; // RQ22
            next_ncnt = '0;
        end
        else if (line == DRSH_LN_NULL)
        begin
            // long null drops a partial word
            if (ncnt < bit_time_in)
            begin
                next_ncnt = ncnt + 7'd1;
            end
            else
            begin
                next_nbits = '0; // RQ22
            end
        end
        else
        begin
            next_ncnt = '0;
            if (prev_line == DRSH_LN_NULL)
            begin
                next_shift = {line == DRSH_LN_ONE, shift[31:1]}; // RQ21
                if (nbits == `DRSH_LAST_BIT)
                begin
                    eos = 1'b1;
                    next_nbits = '0;
                end
                else
                begin
                    next_nbits = nbits + 5'd1;
                end
            end
        end
        if (read_in)
        begin
            next_got = got | (read_sel_in ? 2'b10 : 2'b01); // RQ1
            if (next_got == 2'b11)
            begin
                next_ready_n = 1'b1; // RQ24
                next_got = 2'b00;
            end
        end
        // a new word wins over a read in the same cycle
        if (eos && (!decode_en_in || next_shift[9:8] == match_in))
        begin
            next_word = {~^next_shift, next_shift[30:0]}; // RQ23
            next_ready_n = 1'b0; // RQ24
            next_got = 2'b00;
        end
        if (clr_in)
        begin
            next_shift = '0; // RQ25
            next_nbits = '0;
            next_ncnt = '0;
            next_word = '0;
            next_ready_n = 1'b1;
            next_got = 2'b00;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prev_line <= DRSH_LN_NULL;
            shift <= '0;
            nbits <= '0;
            ncnt <= '0;
            word_out <= '0;
            ready_n_out <= 1'b1;
            got <= 2'b00;
        end
        else
        begin
            prev_line <= next_prev_line;
            shift <= next_shift;
            nbits <= next_nbits;
            ncnt <= next_ncnt;
            word_out <= next_word;
            ready_n_out <= next_ready_n;
            got <= next_got;
        end
    end

endmodule : drsh_rx
`default_nettype wire

/* drsh_host_port.sv */
// serial host port, top level
//
// Summary of operation
// RQ1 - select low reads byte 1, high byte 2
// RQ2 - rx1 enable drives its selected byte
// RQ3 - rx2 enable acts only while rx1 enable is high
// RQ4 - low load strobe latches byte 1
// RQ5 - host pulses high load strobe only after low one
// RQ6 - tx ready drops on load, rises when idle and empty
// RQ7 - ones and zeros each pulse their own output
// RQ8 - tx clock is clock divided by 10 or 80
// RQ9 - master reset is active low
// RQ10 - data bit control enable active low, open is inactive
// RQ11 - eleven control bits load on strobe rising edge
// RQ12 - bus bit 4 enables parity in sent bit 32
// RQ13 - bus bit 5 low loops tx outputs into receivers
// RQ14 - bus bit 6 enables rx1 label match to bits 7, 8
// RQ15 - bus bit 9 enables rx2 label match to bits 10, 11
// RQ16 - bus bit 12 low odd parity, high even
// RQ17 - bus bit 13 picks tx divisor 10 or 80
// RQ18 - bus bit 14 picks rx divisor 10 or 80
// RQ19 - host applies master reset after control writes
// RQ20 - fixed word-bit to bus-bit map for both bytes
// RQ21 - word bit 1 goes first both ways
// RQ22 - receivers drop words with out-of-range levels
// RQ23 - stored bit 32 is 0 on odd parity, 1 on error
// RQ24 - ready drops on a word, rises when both bytes read
// RQ25 - master reset clears all but control word (tx clock divider and tx_clk_out keep running)
// RQ26 - enable high forces parity; low lets bit 4 choose
// RQ27 - strobes active low; bus driven while low
`timescale 1ns/1ps
`default_nettype none
`include "drsh_consts.svh"
module drsh_host_port
    import drsh_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic master_reset_n_in,
    input wire logic [15:0] bd_in,
    output logic [15:0] bd_out,
    output logic bd_oe_out,
    input wire logic byte_select_in,
    input wire logic rx1_read_enable_n_in,
    input wire logic rx2_read_enable_n_in,
    input wire logic load_low_byte_n_in,
    input wire logic load_high_byte_n_in,
    input wire logic control_word_strobe_in,
    input wire logic transmit_enable_in,
    input wire logic data_bit_control_enable_n_in,
    input wire logic [1:0] rx1_line_in,
    input wire logic [1:0] rx2_line_in,
    output logic rx1_word_ready_n_out,
    output logic rx2_word_ready_n_out,
    output logic tx_ready_out,
    output logic line_out_ones_out,
    output logic line_out_zeros_out,
    output logic tx_clk_out
);
    // ------------------------------------------------------------
    // word and bus mapping
    // ------------------------------------------------------------
    function automatic logic [15:0] drsh_byte1(input drsh_word_t w);
        drsh_byte1 = {w[12], w[11], w[10], w[9], w[8], w[30], w[29],
                      w[31], w[0], w[1], w[2], w[3], w[4], w[5], w[6],
                      w[7]};
    endfunction : drsh_byte1

    function automatic drsh_word_t drsh_pack(input logic [15:0] b1,
                                             input logic [15:0] b2);
        drsh_pack = {b1[8], b1[10], b1[9], b2, b1[15], b1[14], b1[13],
                     b1[12], b1[11], b1[0], b1[1], b1[2], b1[3], b1[4],
                     b1[5], b1[6], b1[7]};
    endfunction : drsh_pack

    function automatic logic [15:0] drsh_pick(input drsh_word_t w,
                                              input logic sel);
        drsh_pick = sel ? w[28:13] : drsh_byte1(w);
    endfunction : drsh_pick

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic en1_q, en2_q, pl1_q, pl2_q, cws_q;
    logic mr;
    drsh_cw_t cw;
    drsh_cw_t next_cw;
    logic [15:0] next_bd_out;
    logic next_bd_oe;
    logic rx1_read, rx2_read;
    drsh_word_t rx1_word, rx2_word;
    logic [1:0] rx1_src, rx2_src;
    logic [6:0] rx_bit_time;
    logic [15:0] low_byte;
    logic [15:0] next_low_byte;
    logic low_valid;
    logic next_low_valid;
    logic push;
    logic [6:0] half;
    logic [6:0] hcnt;
    logic [6:0] next_hcnt;
    logic tick;
    logic next_tx_clk;
    drsh_tx_state_t state;
    drsh_tx_state_t next_state;
    drsh_word_t shift;
    drsh_word_t next_shift;
    logic [4:0] bitn;
    logic [4:0] next_bitn;
    logic [3:0] gap;
    logic [3:0] next_gap;
    logic pop;
    logic par_bit;
    logic next_ones, next_zeros, next_tx_ready;

    drsh_fifo_if #(.W(`DRSH_WORD_W)) fifo_bus ();

    assign mr = ~master_reset_n_in; // RQ9

    // ------------------------------------------------------------
    // strobe history
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            en1_q <= 1'b1;
            en2_q <= 1'b1;
            pl1_q <= 1'b1;
            pl2_q <= 1'b1;
            cws_q <= 1'b0;
        end
        else
        begin
            en1_q <= rx1_read_enable_n_in;
            en2_q <= rx2_read_enable_n_in;
            pl1_q <= load_low_byte_n_in;
            pl2_q <= load_high_byte_n_in;
            cws_q <= control_word_strobe_in;
        end
    end

    // ------------------------------------------------------------
    // control word and data bus
    // ------------------------------------------------------------
    always_comb
    begin
        next_cw = cw;
        // master reset leaves this alone
        if (control_word_strobe_in && !cws_q)
        begin
            next_cw = bd_in[`DRSH_CW_MSB:`DRSH_CW_LSB]; // RQ11
        end
        next_bd_oe = !rx1_read_enable_n_in || !rx2_read_enable_n_in; // RQ27
        if (!rx1_read_enable_n_in)
        begin
            next_bd_out = drsh_pick(rx1_word, byte_select_in); // RQ2 RQ20
        end
        else if (!rx2_read_enable_n_in)
        begin
            next_bd_out = drsh_pick(rx2_word, byte_select_in); // RQ3 RQ20
        end
        else
        begin
            next_bd_out = 16'h0000;
        end
        // byte read counted at strobe start
        rx1_read = !rx1_read_enable_n_in && en1_q; // RQ1
        rx2_read = !rx2_read_enable_n_in && en2_q
                   && rx1_read_enable_n_in; // RQ3
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cw <= `DRSH_CW_RESET;
            bd_out <= 16'h0000;
            bd_oe_out <= 1'b0;
        end
        else
        begin
            cw <= next_cw;
            bd_out <= next_bd_out;
            bd_oe_out <= next_bd_oe;
        end
    end

    // ------------------------------------------------------------
    // receivers
    // ------------------------------------------------------------
    always_comb
    begin
        rx_bit_time = cw[`DRSH_CW_RX_DIV] ? `DRSH_DIV_SLOW
                                           : `DRSH_DIV_FAST; // RQ18
        if (!cw[`DRSH_CW_SELF_TEST_N])
        begin
            // loopback: rx2 sees the complement
            rx1_src = {line_out_ones_out, line_out_zeros_out}; // RQ13
            rx2_src = {line_out_zeros_out, line_out_ones_out}; // RQ13
        end
        else
        begin
            rx1_src = rx1_line_in;
            rx2_src = rx2_line_in;
        end
    end

    drsh_rx rx1 (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .clr_in(mr),
        .line_in(rx1_src),
        .decode_en_in(cw[`DRSH_CW_RX1_DEC]), // RQ14
        .match_in({cw[`DRSH_CW_RX1_B10], cw[`DRSH_CW_RX1_B9]}),
        .bit_time_in(rx_bit_time),
        .read_in(rx1_read),
        .read_sel_in(byte_select_in),
        .word_out(rx1_word),
        .ready_n_out(rx1_word_ready_n_out)
    );

    drsh_rx rx2 (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .clr_in(mr),
        .line_in(rx2_src),
        .decode_en_in(cw[`DRSH_CW_RX2_DEC]), // RQ15
        .match_in({cw[`DRSH_CW_RX2_B10], cw[`DRSH_CW_RX2_B9]}),
        .bit_time_in(rx_bit_time),
        .read_in(rx2_read),
        .read_sel_in(byte_select_in),
        .word_out(rx2_word),
        .ready_n_out(rx2_word_ready_n_out)
    );

    // ------------------------------------------------------------
    // transmit loading
    // ------------------------------------------------------------
    always_comb
    begin
        next_low_byte = low_byte;
        next_low_valid = low_valid;
        push = 1'b0;
        if (!load_low_byte_n_in && pl1_q)
        begin
            next_low_byte = bd_in; // RQ4
            next_low_valid = 1'b1;
        end
        else if (!load_high_byte_n_in && pl2_q && low_valid)
        begin
            // a full fifo ignores the load
            push = fifo_bus.in_ready; // RQ5
            next_low_valid = 1'b0;
        end
        if (mr)
        begin
            next_low_valid = 1'b0; // RQ25
            push = 1'b0;
        end
    end

    assign fifo_bus.in_valid = push;
    assign fifo_bus.in_data = drsh_pack(low_byte, bd_in); // RQ20
    assign fifo_bus.out_ready = pop;

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            low_byte <= 16'h0000;
            low_valid <= 1'b0;
        end
        else
        begin
            low_byte <= next_low_byte;
            low_valid <= next_low_valid;
        end
    end

    drsh_fifo #(.WIDTH(`DRSH_WORD_W), .DEPTH(`DRSH_FIFO_DEPTH)) tx_fifo (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .clr_in(mr),
        .f(fifo_bus)
    );

    // ------------------------------------------------------------
    // transmit clock divider
    // ------------------------------------------------------------
    always_comb
    begin
        half = cw[`DRSH_CW_TX_DIV] ? `DRSH_HALF_SLOW
                                    : `DRSH_HALF_FAST; // RQ17
        // >= stays sane if the divisor drops mid count
        tick = (hcnt >= half - 7'd1);
        next_hcnt = tick ? 7'd0 : hcnt + 7'd1;
        next_tx_clk = tick ? !tx_clk_out : tx_clk_out; // RQ8
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            hcnt <= 7'd0;
            tx_clk_out <= 1'b0;
        end
        else
        begin
            hcnt <= next_hcnt;
            tx_clk_out <= next_tx_clk;
        end
    end

    // ------------------------------------------------------------
    // transmit sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_shift = shift;
        next_bitn = bitn;
        next_gap = gap;
        pop = 1'b0;
        // odd parity unless inverted
        par_bit = ~^fifo_bus.out_data[30:0]
                  ^ cw[`DRSH_CW_TX_PAR_INV]; // RQ16
        unique case (state)
            DRSH_TX_IDLE:
            begin
                if (tick && transmit_enable_in && fifo_bus.out_valid)
                begin
                    pop = 1'b1;
                    next_shift = fifo_bus.out_data;
                    if (data_bit_control_enable_n_in
                        || cw[`DRSH_CW_PAR_EN]) // RQ10 RQ12 RQ26
                    begin
                        next_shift[31] = par_bit; // RQ26
                    end
                    next_bitn = 5'd0;
                    next_state = DRSH_TX_DATA;
                end
            end
            DRSH_TX_DATA:
            begin
                if (tick)
                begin
                    next_state = DRSH_TX_NULL;
                end
            end
            DRSH_TX_NULL:
            begin
                if (tick)
                begin
                    next_shift = {1'b0, shift[31:1]}; // RQ21
                    if (bitn == `DRSH_LAST_BIT)
                    begin
                        next_gap = 4'd0;
                        next_state = DRSH_TX_GAP;
                    end
                    else
                    begin
                        next_bitn = bitn + 5'd1;
                        next_state = DRSH_TX_DATA;
                    end
                end
            end
            DRSH_TX_GAP:
            begin
                if (tick)
                begin
                    next_gap = gap + 4'd1;
                    if (next_gap == `DRSH_GAP_HALVES)
                    begin
                        next_state = DRSH_TX_IDLE;
                    end
                end
            end
        endcase
        if (mr)
        begin
            next_state = DRSH_TX_IDLE; // RQ25
            pop = 1'b0;
        end
        next_ones = (next_state == DRSH_TX_DATA) && next_shift[0]; // RQ7
        next_zeros = (next_state == DRSH_TX_DATA) && !next_shift[0]; // RQ7
        next_tx_ready = !fifo_bus.out_valid && !push && !low_valid
                        && (next_state == DRSH_TX_IDLE); // RQ6
        if (mr)
        begin
            next_tx_ready = 1'b1; // RQ25
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= DRSH_TX_IDLE;
            shift <= '0;
            bitn <= 5'd0;
            gap <= 4'd0;
            line_out_ones_out <= 1'b0;
            line_out_zeros_out <= 1'b0;
            tx_ready_out <= 1'b1;
        end
        else
        begin
            state <= next_state;
            shift <= next_shift;
            bitn <= next_bitn;
            gap <= next_gap;
            line_out_ones_out <= next_ones;
            line_out_zeros_out <= next_zeros;
            tx_ready_out <= next_tx_ready;
        end
    end

endmodule : drsh_host_port
`default_nettype wire

/* drsh_port_props.sv */
// port checker for the host port
`timescale 1ns/1ps
`default_nettype none
module drsh_port_chk
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic master_reset_n_in,
    input wire logic rx1_read_enable_n_in,
    input wire logic rx2_read_enable_n_in,
    input wire logic [15:0] bd_out,
    input wire logic bd_oe_out,
    input wire logic tx_ready_out,
    input wire logic line_out_ones_out,
    input wire logic line_out_zeros_out,
    input wire logic tx_clk_out,
    input wire logic rx1_word_ready_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_rx1_drive:
    assert property (!rx1_read_enable_n_in |=> bd_oe_out)
        else $error("rx1 read undriven");
    a_rx2_drive:
    assert property (rx1_read_enable_n_in && !rx2_read_enable_n_in
        |=> bd_oe_out) else $error("rx2 read undriven");
    a_bus_release:
    assert property (rx1_read_enable_n_in && rx2_read_enable_n_in
        |=> !bd_oe_out) else $error("bus held");
    a_idle_bus_zero:
    assert property (!bd_oe_out |-> bd_out == 16'h0000)
        else $error("bus value while released");
    a_lines_apart:
    assert property (!(line_out_ones_out && line_out_zeros_out))
        else $error("both lines high");
    a_mr_clears:
    assert property (!master_reset_n_in |=> tx_ready_out
        && rx1_word_ready_n_out && !line_out_ones_out)
        else $error("reset left state");
    a_ready_quiet:
    assert property (tx_ready_out |-> !line_out_ones_out
        && !line_out_zeros_out) else $error("sending while ready");
    // five high cycles hold for both divisors
    a_txclk_high:
    assert property ($rose(tx_clk_out) |-> tx_clk_out [*5])
        else $error("tx clock high short");
    cover property (!rx1_read_enable_n_in && !rx2_read_enable_n_in);
    cover property ($fell(tx_ready_out));
    cover property ($fell(rx1_word_ready_n_out));
endmodule : drsh_port_chk
bind drsh_host_port drsh_port_chk chk_u (.core_clk_in, .rst_b_in,
    .master_reset_n_in, .rx1_read_enable_n_in, .rx2_read_enable_n_in,
    .bd_out, .bd_oe_out, .tx_ready_out, .line_out_ones_out,
    .line_out_zeros_out, .tx_clk_out, .rx1_word_ready_n_out);
`default_nettype wire

/* drsh_line_src.sv */
// remote word sender driving one receive line
`timescale 1ns/1ps
`default_nettype none
module drsh_line_src
(
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [31:0] word_in,
    output logic [1:0] line_out
);
    initial line_out = 2'b00;
    // fast rate: 5 clocks level, 5 null
    always @(posedge clk_in)
        if (go_in)
            for (int i = 0; i < 32; i++)
            begin
                #1 line_out = word_in[i] ? 2'b10 : 2'b01;
                repeat (5) @(posedge clk_in);
                #1 line_out = 2'b00;
                repeat (5) @(posedge clk_in);
            end
endmodule : drsh_line_src
`default_nettype wire

/* testbench.sv */
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, mr_n = 1, sel = 0, e1 = 1, e2 = 1, cws = 0;
    logic pl1 = 1, pl2 = 1, txen = 0, go = 0, prev, oe, r1n, r2n;
    logic txr, ones, zeros, tck;
    logic [15:0] bd = 16'h0000, bdo;
    logic [1:0] l1, l2;
    logic [31:0] w1 = 32'h1234_5678, w2 = 32'h8765_4321;
    int fail_count = 0, cmp_count = 0, cyc = 0, n1, n0, nt;
    always #5 clk = ~clk;
    drsh_line_src src1_u (.clk_in(clk), .go_in(go), .word_in(w1),
        .line_out(l1));
    drsh_line_src src2_u (.clk_in(clk), .go_in(go), .word_in(w2),
        .line_out(l2));
    // open enable pin tied high
    drsh_host_port dut_u (.core_clk_in(clk), .rst_b_in(rst_b),
        .master_reset_n_in(mr_n), .bd_in(bd), .bd_out(bdo),
        .bd_oe_out(oe), .byte_select_in(sel), .rx1_read_enable_n_in(e1),
        .rx2_read_enable_n_in(e2), .load_low_byte_n_in(pl1),
        .load_high_byte_n_in(pl2), .control_word_strobe_in(cws),
        .transmit_enable_in(txen), .data_bit_control_enable_n_in(1'b1),
        .rx1_line_in(l1), .rx2_line_in(l2), .rx1_word_ready_n_out(r1n),
        .rx2_word_ready_n_out(r2n), .tx_ready_out(txr),
        .line_out_ones_out(ones), .line_out_zeros_out(zeros),
        .tx_clk_out(tck));
    function automatic logic [15:0] lo(input logic [31:0] w);
        return {w[12:8], w[30:29], ~^w, {<<{w[7:0]}}};
    endfunction : lo
    function automatic logic [15:0] hi(input logic [31:0] w);
        return w[28:13];
    endfunction : hi
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk)
        if (++cyc == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    task automatic rd(input logic a, b, s, input logic [15:0] exp);
        @(posedge clk) #1 {e1, e2, sel} = {a, b, s};
        repeat (2) @(posedge clk);
        #1 chk(oe, 1);
        chk(bdo, exp);
        {e1, e2} = 2'b11;
        repeat (2) @(posedge clk);
        #1 chk(oe, 0);
    endtask : rd
    task automatic ld(input logic [31:0] w);
        @(posedge clk) #1 {bd, pl1} = {lo(w), 1'b0};
        @(posedge clk) #1 pl1 = 1;
        @(posedge clk) #1 {bd, pl2} = {hi(w), 1'b0};
        @(posedge clk) #1 pl2 = 1;
        @(posedge clk) #1;
    endtask : ld
    task automatic edges(input int n, input int exp);
        prev = tck;
        nt = 0;
        repeat (n)
        begin
            @(posedge clk) #1 nt += (tck & !prev);
            prev = tck;
        end
        chk(nt, exp);
    endtask : edges
    task automatic test_rx;
        @(posedge clk) #1 go = 1;
        @(posedge clk) #1 go = 0;
        for (n1 = 0; n1 < 500 && r1n !== 1'b0; n1++)
            @(posedge clk) #1;
        chk({r1n, r2n}, 0);
        rd(0, 0, 0, lo(w1));
        rd(1, 0, 1, hi(w2));
        chk(r2n, 0);
        rd(0, 1, 1, hi(w1));
        rd(1, 0, 0, lo(w2));
        chk({r1n, r2n}, 2'b11);
        $display("test_rx done");
    endtask : test_rx
    task automatic test_tx;
        ld(w1);
        chk(txr, 0);
        @(posedge clk) #1 mr_n = 0;
        @(posedge clk) #1 mr_n = 1;
        chk(txr, 1);
        ld(w1);
        {txen, n1, n0} = {1'b1, 64'd0};
        for (nt = 0; nt < 1000 && txr !== 1'b1; nt++)
        begin
            @(posedge clk) #1;
            n1 += ones;
            n0 += zeros;
        end
        chk(n1, 65);
        chk(n0, 95);
        edges(100, 10);
        @(posedge clk) #1 {bd, cws} = {16'h2020, 1'b1};
        @(posedge clk) #1 {cws, mr_n} = 2'b00;
        @(posedge clk) #1 mr_n = 1;
        repeat (80) @(posedge clk);
        edges(160, 2);
        $display("test_tx done");
    endtask : test_tx
    initial
    begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        test_rx();
        test_tx();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
